// File: logic/scp_core.sv
// Behaviour
// RULE_01 - every enabled input is converted in each round, none blocks another.
// RULE_02 - a counter crossing of the threshold in the chosen direction adds exactly one.
// RULE_03 - crossings at least 100 us apart are counted separately; the code does so only for a lone counter (10 kHz rounds).
// RULE_04 - only one input can be the counter or event input, the rest stay analog.
// RULE_05 - event mode stores each crossing with a 0.1 ms time stamp in local memory; the code drops crossings while its 16 entries are full.
// RULE_06 - the counter path follows input signals up to 5 kHz; with analog inputs also on, code samples it at 5 or 2.5 kHz.
// RULE_07 - round rate is 40, 20, 3.33 or 2.5 kHz for one to four analog inputs.
// RULE_08 - round rate is 10 kHz for a lone counter and 5 kHz with one analog input.
// RULE_09 - each input picks the wide or low range pin, low range after reset.
// RULE_10 - each output channel A to D has four push-pull states.
// RULE_11 - each output indicator shows green, orange, red or off per state.
// RULE_12 - output power has 16 levels by gating at a 625 Hz period.
// RULE_13 - level n keeps the channel on for n sixteenths of the period.
// RULE_14 - a per-channel maximum level caps the applied level.
// RULE_15 - the digital channel can run as an up/down counter.
// RULE_16 - detectors get an init output and echoes are timed at 50 Hz or 25 Hz each.
// RULE_17 - a crossing needs the previous sample on the other side of the threshold.
`timescale 1ns/10ps
`include "scp_defs.svh"
module scp_core
  import scp_pkg::*;
#(
  parameter int CLK_HZ = `SCP_CLK_HZ,
  parameter int STAMP_HZ = `SCP_STAMP_HZ,
  parameter int PWM_HZ = `SCP_PWM_HZ,
  parameter int SONIC_HZ = `SCP_SONIC_HZ,
  parameter int F_1A = `SCP_F_1A,
  parameter int F_2A = `SCP_F_2A,
  parameter int F_3A = `SCP_F_3A,
  parameter int F_4A = `SCP_F_4A,
  parameter int F_1C = `SCP_F_1C,
  parameter int F_1C1A = `SCP_F_1C1A,
  parameter int EV_AW = 4
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic ADC_START,
  output logic [1:0] ADC_SEL,
  output logic ADC_WIDE,
  input wire logic ADC_DONE,
  input wire logic [11:0] ADC_DATA,
  input wire logic [1:0] SONIC_ECHO,
  output logic [1:0] SONIC_INIT,
  output logic [7:0] OUT_DRIVE,
  output logic [3:0] LED_GREEN,
  output logic [3:0] LED_RED
);
  localparam logic [31:0] C_1A = 32'(CLK_HZ / F_1A);
  localparam logic [31:0] C_2A = 32'(CLK_HZ / F_2A);
  localparam logic [31:0] C_3A = 32'(CLK_HZ / F_3A);
  localparam logic [31:0] C_4A = 32'(CLK_HZ / F_4A);
  localparam logic [31:0] C_1C = 32'(CLK_HZ / F_1C);
  localparam logic [31:0] C_1C1A = 32'(CLK_HZ / F_1C1A);
  localparam logic [31:0] C_STAMP = 32'(CLK_HZ / STAMP_HZ);
  localparam logic [31:0] C_SLOT = 32'(CLK_HZ / (PWM_HZ * `SCP_PWM_STEPS));
  localparam logic [31:0] C_PING = 32'(CLK_HZ / SONIC_HZ);

  // refuse rates the dividers cannot reach
  if (C_SLOT < 1 || C_STAMP < 1 || C_PING < 1 || C_1A < 1) begin : g_chk
    $error("scp_core: clock too slow for the requested rates");
  end
  if (EV_AW < 1 || EV_AW > 10) begin : g_chk_ev
    $error("scp_core: event memory depth out of range");
  end

  ////////////////////////////////////////////////////////////////////
  // register bus
  scp_ctrl_t ctrl;
  logic [11:0] thresh;
  logic [3:0] range;
  logic [7:0] ostate;
  logic [15:0] power;
  logic [15:0] maxpwr;
  logic [31:0] count;
  logic [31:0] sonic_t [2];
  logic [31:0] updn;
  logic [11:0] smp [4];
  scp_evt_t ev_mem [2**EV_AW];
  logic [EV_AW:0] ev_wp;
  logic [EV_AW:0] ev_rp;
  logic [31:0] next_rdata;

  // one wait cycle: request seen, answer next cycle
  wire rd_go = AVS_READ & ~AVS_WAITREQUEST;
  wire wr_go = AVS_WRITE & ~AVS_WAITREQUEST & (AVS_BYTEENABLE == 4'hF);
  wire wr_ctrl = wr_go & (AVS_ADDRESS == `SCP_A_CTRL);
  wire cnt_clr = wr_go & (AVS_ADDRESS == `SCP_A_COUNT);
  wire updn_clr = wr_go & (AVS_ADDRESS == `SCP_A_SONIC0);
  wire [EV_AW:0] ev_lvl = ev_wp - ev_rp;
  wire ev_empty = (ev_lvl == '0);
  wire ev_full = ev_lvl[EV_AW];
  wire ev_pop = rd_go & (AVS_ADDRESS == `SCP_A_EVDATA) & ~ev_empty;

  // read mux, unmapped words read as zero
  always_comb begin
    next_rdata = 32'h0;
    if (AVS_ADDRESS == `SCP_A_CTRL) begin
      next_rdata = 32'(ctrl);
    end else if (AVS_ADDRESS == `SCP_A_THRESH) begin
      next_rdata = {20'h0, thresh};
    end else if (AVS_ADDRESS == `SCP_A_RANGE) begin
      next_rdata = {28'h0, range};
    end else if (AVS_ADDRESS == `SCP_A_OSTATE) begin
      next_rdata = {24'h0, ostate};
    end else if (AVS_ADDRESS == `SCP_A_POWER) begin
      next_rdata = {16'h0, power};
    end else if (AVS_ADDRESS == `SCP_A_MAXPWR) begin
      next_rdata = {16'h0, maxpwr};
    end else if (AVS_ADDRESS == `SCP_A_COUNT) begin
      next_rdata = count;
    end else if (AVS_ADDRESS == `SCP_A_EVDATA) begin
      next_rdata = ev_empty ? 32'h0 : ev_mem[ev_rp[EV_AW-1:0]];
    end else if (AVS_ADDRESS == `SCP_A_EVLEVEL) begin
      next_rdata = 32'(ev_lvl);
    end else if (AVS_ADDRESS == `SCP_A_SMP01) begin
      next_rdata = {4'h0, smp[1], 4'h0, smp[0]};
    end else if (AVS_ADDRESS == `SCP_A_SMP23) begin
      next_rdata = {4'h0, smp[3], 4'h0, smp[2]};
    end else if (AVS_ADDRESS == `SCP_A_SONIC0) begin
      next_rdata = (ctrl.sonic_mode == SN_UPDN) ? updn : sonic_t[0];
    end else if (AVS_ADDRESS == `SCP_A_SONIC1) begin
      next_rdata = sonic_t[1];
    end
  end

  // bus handshake and data capture
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0;
    end else begin
      AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
      if (AVS_READ & AVS_WAITREQUEST) begin
        AVS_READDATA <= next_rdata;
      end
    end
  end

  // software written settings; range defaults to the low pin
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ctrl <= '0;
      thresh <= 12'h0;
      range <= `SCP_RST_RANGE; // RULE_09
      ostate <= 8'h0;
      power <= 16'h0;
      maxpwr <= `SCP_RST_MAXPWR;
    end else if (wr_go) begin
      if (wr_ctrl) begin
        ctrl <= scp_ctrl_t'(AVS_WRITEDATA[`SCP_CTRL_W-1:0]);
      end else if (AVS_ADDRESS == `SCP_A_THRESH) begin
        thresh <= AVS_WRITEDATA[11:0];
      end else if (AVS_ADDRESS == `SCP_A_RANGE) begin
        range <= AVS_WRITEDATA[3:0]; // RULE_09
      end else if (AVS_ADDRESS == `SCP_A_OSTATE) begin
        ostate <= AVS_WRITEDATA[7:0]; // RULE_10
      end else if (AVS_ADDRESS == `SCP_A_POWER) begin
        power <= AVS_WRITEDATA[15:0];
      end else if (AVS_ADDRESS == `SCP_A_MAXPWR) begin
        maxpwr <= AVS_WRITEDATA[15:0]; // RULE_14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // acquisition rounds
  // a 2-bit select means only one input can ever be the counter
  wire [3:0] cnt_mask = ctrl.cnt_en ? (4'h1 << ctrl.cnt_ch) : 4'h0; // RULE_04
  wire [3:0] ain = ctrl.ain_en & ~cnt_mask;
  wire [3:0] act = ain | cnt_mask;
  wire [2:0] n_ain = 3'($countones(ain));
  // more inputs than a row allows fall back to the slowest rate
  wire [31:0] period = !ctrl.cnt_en ? // RULE_07
    ((n_ain == 3'h1) ? C_1A : (n_ain == 3'h2) ? C_2A : (n_ain == 3'h3) ? C_3A : C_4A) :
    ((n_ain == 3'h0) ? C_1C : (n_ain == 3'h1) ? C_1C1A : C_4A); // RULE_08
  logic [31:0] rate_cnt;
  wire round_tick = (rate_cnt >= period - 32'h1);
  scp_state_t state;
  logic [1:0] idx;
  wire last = (idx == 2'h3);
  wire conv_done = (state == S_CONV) & ADC_DONE;

  // round divider; a tick during a busy round is dropped
  always_ff @(posedge CLOCK) begin
    if (SRST || wr_ctrl || round_tick) begin
      rate_cnt <= 32'h0;
    end else begin
      rate_cnt <= rate_cnt + 32'h1;
    end
  end

  // walk all enabled inputs in one round
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state <= S_IDLE;
      idx <= 2'h0;
      ADC_START <= 1'b0;
      ADC_SEL <= 2'h0;
      ADC_WIDE <= 1'b0;
    end else begin
      ADC_START <= 1'b0;
      case (state)
        S_IDLE: begin
          idx <= 2'h0;
          if (round_tick && act != 4'h0) begin
            state <= S_NEXT; // RULE_01
          end
        end
        S_NEXT: begin
          if (act[idx]) begin
            ADC_START <= 1'b1;
            ADC_SEL <= idx;
            ADC_WIDE <= range[idx]; // RULE_09
            state <= S_CONV;
          end else if (last) begin
            state <= S_IDLE;
          end else begin
            idx <= idx + 2'h1;
          end
        end
        S_CONV: begin
          if (ADC_DONE) begin
            state <= last ? S_IDLE : S_NEXT;
            idx <= idx + 2'h1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // counter and event input
  logic [31:0] stamp_div;
  logic [19:0] stamp;
  logic prev_ok;
  wire is_cnt = conv_done & ctrl.cnt_en & (idx == ctrl.cnt_ch);
  wire [11:0] prev = smp[idx];
  // both samples must straddle the threshold, one sample per round
  wire up_x = (prev < thresh) & (ADC_DATA >= thresh); // RULE_17
  wire dn_x = (prev >= thresh) & (ADC_DATA < thresh); // RULE_17
  wire cnt_hit = is_cnt & prev_ok & (ctrl.dir_down ? dn_x : up_x); // RULE_02
  wire ev_push = cnt_hit & ctrl.evt_mode & ~ev_full;

  // 0.1 ms time base for stamps
  always_ff @(posedge CLOCK) begin
    if (SRST || stamp_div >= C_STAMP - 32'h1) begin
      stamp_div <= 32'h0;
    end else begin
      stamp_div <= stamp_div + 32'h1;
    end
    if (SRST) begin
      stamp <= 20'h0;
    end else if (stamp_div >= C_STAMP - 32'h1) begin
      stamp <= stamp + 20'h1; // RULE_05
    end
  end

  // samples, pulse count and event memory; a hit beats a clear
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      smp <= '{default: 12'h0};
      count <= 32'h0;
      prev_ok <= 1'b0;
      ev_wp <= '0;
      ev_rp <= '0;
    end else begin
      if (conv_done) begin
        smp[idx] <= ADC_DATA;
      end
      if (wr_ctrl) begin
        prev_ok <= 1'b0;
      end else if (is_cnt) begin
        prev_ok <= 1'b1;
      end
      if (cnt_clr) begin
        count <= cnt_hit ? 32'h1 : 32'h0; // RULE_03
      end else if (cnt_hit) begin
        count <= count + 32'h1; // RULE_06
      end
      if (ev_push) begin
        ev_mem[ev_wp[EV_AW-1:0]] <= '{stamp: stamp, sample: ADC_DATA}; // RULE_05
        ev_wp <= ev_wp + 1'b1;
      end
      if (ev_pop) begin
        ev_rp <= ev_rp + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // digital channel: motion detectors or up/down counter
  logic [1:0] e1;
  logic [1:0] e2;
  logic [1:0] e3;
  logic [1:0] echo;
  logic [1:0] echo_d;
  logic [31:0] ping_div;
  logic [31:0] tcnt;
  logic sn_sel;
  // a change counts only once stages two and three agree
  wire [1:0] next_echo = (e2 & e3) | (echo & (e2 ^ e3));
  wire [1:0] echo_rise = echo & ~echo_d;
  wire ping = (ping_div >= C_PING - 32'h1);
  wire sonic_on = (ctrl.sonic_mode == SN_ONE) | (ctrl.sonic_mode == SN_TWO);
  wire fire_d = (ctrl.sonic_mode == SN_TWO) & sn_sel;
  wire updn_step = (ctrl.sonic_mode == SN_UPDN) & echo_rise[0];

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      {e1, e2, e3, echo, echo_d} <= 10'h0;
      ping_div <= 32'h0;
      tcnt <= 32'h0;
      sn_sel <= 1'b0;
      SONIC_INIT <= 2'h0;
      sonic_t <= '{default: 32'h0};
      updn <= 32'h0;
    end else begin
      e1 <= SONIC_ECHO;
      e2 <= e1;
      e3 <= e2;
      echo <= next_echo;
      echo_d <= echo;
      ping_div <= ping ? 32'h0 : ping_div + 32'h1;
      tcnt <= tcnt + 32'h1;
      if (ping && sonic_on) begin
        // two detectors share the ping rate, halving each one's rate
        SONIC_INIT <= fire_d ? 2'h2 : 2'h1; // RULE_16
        sn_sel <= ~sn_sel;
        tcnt <= 32'h0;
      end else if (!sonic_on) begin
        SONIC_INIT <= 2'h0;
      end else begin
        for (int d = 0; d < 2; d++) begin
          if (SONIC_INIT[d] && echo_rise[d]) begin
            SONIC_INIT[d] <= 1'b0;
            sonic_t[d] <= tcnt; // RULE_16
          end
        end
      end
      // pulse on line 0, direction on line 1 (high counts down)
      if (updn_clr) begin
        updn <= updn_step ? (echo[1] ? 32'hFFFFFFFF : 32'h1) : 32'h0;
      end else if (updn_step) begin
        updn <= echo[1] ? updn - 32'h1 : updn + 32'h1; // RULE_15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output channels
  logic [31:0] slot_div;
  logic [3:0] phase;
  // one slot is a sixteenth of the period
  always_ff @(posedge CLOCK) begin
    if (SRST || slot_div >= C_SLOT - 32'h1) begin
      slot_div <= 32'h0;
    end else begin
      slot_div <= slot_div + 32'h1;
    end
    if (SRST) begin
      phase <= 4'h0;
    end else if (slot_div >= C_SLOT - 32'h1) begin
      phase <= phase + 4'h1; // RULE_12
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_out
    wire [3:0] want = power[4*i +: 4];
    wire [3:0] cap = maxpwr[4*i +: 4];
    wire [3:0] lvl = (want > cap) ? cap : want; // RULE_14
    wire [1:0] st = ostate[2*i +: 2];
    wire on = (phase < lvl); // RULE_13
    // off slots pull both wires low, so the load coasts
    always_ff @(posedge CLOCK) begin
      if (SRST) begin
        OUT_DRIVE[2*i +: 2] <= 2'h0;
        LED_GREEN[i] <= 1'b0;
        LED_RED[i] <= 1'b0;
      end else begin
        OUT_DRIVE[2*i +: 2] <= on ? st : 2'h0; // RULE_10
        LED_GREEN[i] <= st[0]; // RULE_11
        LED_RED[i] <= st[1]; // RULE_11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  bus_wait_a: assert property ((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer not given after one wait cycle");
  range_reset_a: assert property ($fell(SRST) |-> range == 4'h0) // RULE_09
    else $error("range not low after reset");
  count_step_a: assert property (cnt_hit & ~cnt_clr |=> count == $past(count) + 32'h1) // RULE_02
    else $error("count did not step by one");
  count_hold_a: assert property (!cnt_hit & !cnt_clr |=> count == $past(count)) // RULE_17
    else $error("count moved without a crossing");
  adc_pulse_a: assert property (ADC_START |=> !ADC_START ##0 state == S_CONV) // RULE_01
    else $error("converter start not a single pulse");
  ev_store_a: assert property (ev_push & ~ev_pop |=> ev_lvl == $past(ev_lvl) + 1'b1) // RULE_05
    else $error("event not stored");
  pwm_on_a: assert property (OUT_DRIVE[1:0] != 2'h0 |-> $past(phase) < $past(g_out[0].lvl)) // RULE_13
    else $error("channel on outside its level");
  pwm_cap_a: assert property (OUT_DRIVE[1:0] != 2'h0 |-> $past(phase) < $past(maxpwr[3:0])) // RULE_14
    else $error("level above channel maximum");
  led_code_a: assert property (##1 {LED_RED[1], LED_GREEN[1]} == $past(ostate[3:2])) // RULE_11
    else $error("indicator does not follow state");
  init_fire_a: assert property (ping & sonic_on |=> SONIC_INIT != 2'h0 ##1 SONIC_INIT != 2'h3) // RULE_16
    else $error("detector init not raised");

  cnt_hit_c: cover property (cnt_hit ##[1:20] ev_pop);
  round_c: cover property (state == S_CONV & last & ADC_DONE);
  echo_c: cover property (SONIC_INIT[0] & echo_rise[0]);
  updn_c: cover property (updn_step & echo[1]);
endmodule // scp_core

// File: logic/scp_defs.svh
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH
// register byte offsets
`define SCP_A_CTRL 6'h00
`define SCP_A_THRESH 6'h04
`define SCP_A_RANGE 6'h08
`define SCP_A_OSTATE 6'h0C
`define SCP_A_POWER 6'h10
`define SCP_A_MAXPWR 6'h14
`define SCP_A_COUNT 6'h18
`define SCP_A_EVDATA 6'h1C
`define SCP_A_EVLEVEL 6'h20
`define SCP_A_SMP01 6'h24
`define SCP_A_SMP23 6'h28
`define SCP_A_SONIC0 6'h2C
`define SCP_A_SONIC1 6'h30
// field widths and reset values
`define SCP_CTRL_W 11
`define SCP_RST_RANGE 4'h0
`define SCP_RST_MAXPWR 16'hFFFF
// timing in Hz, plus the number of power steps
`define SCP_CLK_HZ 200000000
`define SCP_STAMP_HZ 10000
`define SCP_PWM_HZ 625
`define SCP_PWM_STEPS 16
`define SCP_SONIC_HZ 50
`define SCP_F_1A 40000
`define SCP_F_2A 20000
`define SCP_F_3A 3330
`define SCP_F_4A 2500
`define SCP_F_1C 10000
`define SCP_F_1C1A 5000
`endif

// File: logic/scp_pkg.sv
package scp_pkg;
  // acquisition sequencer
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_NEXT = 2'b01,
    S_CONV = 2'b10
  } scp_state_t;
  // digital channel use
  typedef enum logic [1:0] {
    SN_OFF = 2'b00,
    SN_ONE = 2'b01,
    SN_TWO = 2'b10,
    SN_UPDN = 2'b11
  } scp_sonic_t;
  typedef struct packed {
    scp_sonic_t sonic_mode;
    logic evt_mode;
    logic dir_down;
    logic [1:0] cnt_ch;
    logic cnt_en;
    logic [3:0] ain_en;
  } scp_ctrl_t;
  typedef struct packed {
    logic [19:0] stamp;
    logic [11:0] sample;
  } scp_evt_t;
endpackage

// File: testbench/scp_far_model.sv
`timescale 1ns/10ps
// far side: four-input converter, two motion detectors or an up/down source
module scp_far_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic adc_start,
  input wire logic [1:0] adc_sel,
  output logic adc_done,
  output logic [11:0] adc_data,
  input wire logic [1:0] sonic_init,
  output logic [1:0] sonic_echo,
  input wire logic [47:0] levels,
  input wire logic [7:0] conv_wait,
  input wire logic [15:0] echo_wait,
  input wire logic ud_en,
  input wire logic ud_pulse,
  input wire logic ud_down
);
  logic busy;
  logic [7:0] left;
  logic [1:0] sel;
  logic [15:0] age [2];
  logic [1:0] echo;
  ////////////////////////////////////////////////////////////////////////////
  // converter: data scrambled outside done, so a late sample shows up
  always_ff @(posedge clock) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (srst) begin
      busy <= 1'b0;
      adc_data <= 12'h5A5;
    end else if (adc_start) begin
      busy <= 1'b1;
      left <= conv_wait;
      sel <= adc_sel;
    end else if (busy && left == 8'h00) begin
      busy <= 1'b0;
      adc_done <= 1'b1;
      adc_data <= levels[sel * 12 +: 12];
    end else if (busy) begin
      left <= left - 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // detectors: echo rises echo_wait cycles after init, drops with init
  always_ff @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      if (srst || !sonic_init[i]) begin
        age[i] <= 16'h0000;
        echo[i] <= 1'b0;
      end else begin
        age[i] <= age[i] + 16'h0001;
        echo[i] <= (age[i] >= echo_wait);
      end
    end
  end
  // up/down source takes over the same two lines
  assign sonic_echo = ud_en ? {ud_down, ud_pulse} : echo;
endmodule // scp_far_model

// File: testbench/test_sensor_counter_and_output_pwm.sv
`timescale 1ns/10ps
`include "scp_defs.svh"
module test_sensor_counter_and_output_pwm import scp_pkg::*; ;
  // small clock figure keeps every divider short
  localparam int CLK_HZ = 1600000;
  localparam int SLOT = CLK_HZ / (`SCP_PWM_HZ * `SCP_PWM_STEPS);
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, adc_start, adc_wide, adc_done;
  logic [1:0] adc_sel, sonic_echo, sonic_init;
  logic [11:0] adc_data;
  logic [7:0] out_drive;
  logic [3:0] led_green, led_red;
  logic [47:0] levels = 48'h0;
  logic [7:0] conv_wait = 8'h04;
  logic [15:0] echo_wait = 16'h0028;
  logic ud_en = 1'b0;
  logic ud_pulse = 1'b0;
  logic ud_down = 1'b0;
  logic [31:0] lfsr = 32'h1C53B9CE;
  logic range_on = 1'b0;
  logic [3:0] range_val = 4'h0;
  int starts = 0;
  int bad_count = 0;
  int check_count = 0;
  int f_tab [6] = '{`SCP_F_1A, `SCP_F_2A, `SCP_F_3A, `SCP_F_4A, `SCP_F_1C, `SCP_F_1C1A};
  logic [3:0] ain_tab [6] = '{4'h1, 4'h3, 4'h7, 4'hF, 4'h0, 4'h2};
  logic [3:0] p_tab [4] = '{4'h1, 4'hF, 4'h0, 4'h9};
  logic [3:0] m_tab [4] = '{4'hF, 4'hF, 4'hF, 4'h4};
  always #2.5 clock = ~clock;
  scp_core #(.CLK_HZ(CLK_HZ), .SONIC_HZ(8000)) DUT (
    .CLOCK(clock), .SRST(srst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .ADC_START(adc_start),
    .ADC_SEL(adc_sel), .ADC_WIDE(adc_wide), .ADC_DONE(adc_done), .ADC_DATA(adc_data),
    .SONIC_ECHO(sonic_echo), .SONIC_INIT(sonic_init), .OUT_DRIVE(out_drive),
    .LED_GREEN(led_green), .LED_RED(led_red));
  scp_far_model far (
    .clock(clock), .srst(srst), .adc_start(adc_start), .adc_sel(adc_sel),
    .adc_done(adc_done), .adc_data(adc_data), .sonic_init(sonic_init),
    .sonic_echo(sonic_echo), .levels(levels), .conv_wait(conv_wait),
    .echo_wait(echo_wait), .ud_en(ud_en), .ud_pulse(ud_pulse), .ud_down(ud_down));
  ////////////////////////////////////////////////////////////////////////////
  // helpers: random source, compares, verdict
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  function automatic logic [31:0] mk_ctrl(input logic [3:0] ain, input logic cnt,
      input logic [1:0] ch, input logic down, input logic evt, input scp_sonic_t sm);
    scp_ctrl_t c;
    c = '{sonic_mode: sm, evt_mode: evt, dir_down: down, cnt_ch: ch, cnt_en: cnt, ain_en: ain};
    return {21'h0, c};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // counts and timings only known to a tolerance
  task automatic check_near(input logic [31:0] got, input int exp, input int tol);
    check_count++;
    if ($isunknown(got) || int'(got) < exp - tol || int'(got) > exp + tol) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one avalon access, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, 4'hF, q);
  endtask
  // counter input swings over, under, then further under the threshold
  task automatic toggle(input int k, input logic [11:0] t);
    for (int i = 0; i < k; i++) begin
      levels[35:24] <= t + 12'h080;
      idle(500);
      levels[35:24] <= t - 12'h080;
      idle(500);
      levels[35:24] <= t - 12'h0C0;
      idle(500);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // converter monitor: rounds of input 0 and the range pin chosen
  always @(posedge clock) begin
    if (adc_start === 1'b1 && adc_sel === 2'd0) starts++;
    if (range_on && adc_start === 1'b1) check_eq(adc_wide, range_val[adc_sel]);
  end
  // hang guard
  initial begin
    idle(100000);
    bad_count++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q, r, th, p;
    logic [15:0] mx;
    logic [1:0] col [4];
    int k, on, odd;
    idle(16);
    srst <= 1'b0;
    rd(`SCP_A_RANGE, q);
    check_eq(q, 32'h0);
    rd(`SCP_A_MAXPWR, q);
    check_eq(q, 32'h0000FFFF);
    wr(6'h3C, 32'h12345678);
    rd(6'h3C, q);
    check_eq(q, 32'h0);
    lfsr = lfsr_next(lfsr);
    r = lfsr;
    th = {20'h0, 12'h100 + {1'b0, r[10:0]}};
    wr(`SCP_A_THRESH, th);
    bus(1'b1, `SCP_A_THRESH, 32'h0, 4'h3, q);
    rd(`SCP_A_THRESH, q);
    check_eq(q, th);
    // round rates for each mix of inputs, random range pins and converter delay
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      range_val <= lfsr[3:0];
      conv_wait <= 8'h02 + {5'h0, lfsr[6:4]};
      wr(`SCP_A_RANGE, {28'h0, lfsr[3:0]});
      wr(`SCP_A_CTRL, mk_ctrl(ain_tab[i], i >= 4, 2'd0, 1'b0, 1'b0, SN_OFF));
      idle(400);
      starts = 0;
      range_on <= 1'b1;
      idle(3200);
      range_on <= 1'b0;
      check_near(starts, f_tab[i] / 500, 1);
    end
    // counter on input 2 while input 0 stays analog, up then down
    k = 1 + int'(r[13:12]);
    levels[11:0] <= r[27:16];
    levels[35:24] <= th[11:0] - 12'h080;
    for (int d = 0; d < 2; d++) begin
      wr(`SCP_A_CTRL, mk_ctrl(4'h1, 1'b1, 2'd2, d[0], 1'b0, SN_OFF));
      wr(`SCP_A_COUNT, 32'h0);
      // let the first sample after the control write prime below the crossing
      idle(700);
      toggle(k, th[11:0]);
      rd(`SCP_A_COUNT, q);
      check_eq(q, k);
      rd(`SCP_A_SMP01, q);
      check_eq(q[11:0], r[27:16]);
    end
    // events: stored sample and time stamp, then an empty pop
    wr(`SCP_A_CTRL, mk_ctrl(4'h0, 1'b1, 2'd2, 1'b0, 1'b1, SN_OFF));
    idle(400);
    toggle(3, th[11:0]);
    rd(`SCP_A_EVLEVEL, q);
    check_eq(q, 32'd3);
    for (int i = 0; i < 3; i++) begin
      rd(`SCP_A_EVDATA, q);
      check_eq(q[11:0], th[11:0] + 12'h080);
      if (i > 0) check_near({12'h0, q[31:12] - p[19:0]}, 9, 2);
      p = {12'h0, q[31:12]};
    end
    rd(`SCP_A_EVDATA, q);
    check_eq(q, 32'h0);
    // power levels capped by the per-channel maximum, last case random
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      if (i == 3) p_tab[i] = lfsr[3:0];
      mx = 16'hFFFF;
      mx[4 * i +: 4] = m_tab[i];
      wr(`SCP_A_OSTATE, 32'h2 << (2 * i));
      wr(`SCP_A_POWER, {28'h0, p_tab[i]} << (4 * i));
      wr(`SCP_A_MAXPWR, {16'h0, mx});
      idle(16 * SLOT);
      on = 0;
      odd = 0;
      repeat (16 * SLOT) begin
        @(posedge clock);
        if (out_drive[2 * i +: 2] !== 2'b00) on++;
        if (out_drive[2 * i +: 2] !== 2'b00 && out_drive[2 * i +: 2] !== 2'b10) odd++;
      end
      k = (p_tab[i] < m_tab[i]) ? p_tab[i] : m_tab[i];
      check_eq(on, k * SLOT);
      check_eq(odd, 0);
    end
    // indicator colours for the four states of channel 0, driven at level 15
    wr(`SCP_A_POWER, 32'h0000000F);
    for (int s = 0; s < 4; s++) begin
      wr(`SCP_A_OSTATE, s);
      idle(4);
      k = 0;
      while (out_drive[1:0] !== s[1:0] && k < 3000) begin
        idle(1);
        k++;
      end
      check_eq(out_drive[1:0], s[1:0]);
      idle(2);
      col[s] = {led_red[0], led_green[0]};
    end
    for (int a = 0; a < 4; a++) begin
      for (int b = a + 1; b < 4; b++) check_eq(col[a] != col[b], 1'b1);
    end
    // one detector, then two
    wr(`SCP_A_CTRL, mk_ctrl(4'h0, 1'b0, 2'd0, 1'b0, 1'b0, SN_ONE));
    idle(600);
    rd(`SCP_A_SONIC0, q);
    check_near(q, 44, 4);
    wr(`SCP_A_CTRL, mk_ctrl(4'h0, 1'b0, 2'd0, 1'b0, 1'b0, SN_TWO));
    idle(1200);
    rd(`SCP_A_SONIC1, q);
    check_near(q, 44, 4);
    // up/down source: six up, two down
    ud_en <= 1'b1;
    wr(`SCP_A_CTRL, mk_ctrl(4'h0, 1'b0, 2'd0, 1'b0, 1'b0, SN_UPDN));
    wr(`SCP_A_SONIC0, 32'h0);
    for (int i = 0; i < 8; i++) begin
      ud_down <= (i >= 6);
      idle(10);
      ud_pulse <= 1'b1;
      idle(10);
      ud_pulse <= 1'b0;
    end
    idle(20);
    rd(`SCP_A_SONIC0, q);
    check_eq(q, 32'd4);
    tally_and_finish();
  end
endmodule // test_sensor_counter_and_output_pwm
